// ==== prs_pkg.sv ====
// Package of constants and types for the reset, preload and security block
// Behaviour
// [R01] A 64-bit reprogrammable user signature store holds arbitrary user data.
// [R02] Signature readback works at all times, secured or not.
// [R03] Once security is set, array configuration readback is refused.
// [R04] Security clears only through a full device reprogram. Here power-up reset (nrst_in) also clears it.
// [R05] Each programming cycle erases the configuration automatically first.
// [R06] Preload synchronously forces each registered output high or low.
// [R07] The tester runs preload automatically before sequencing the machine.
// [R08] Power-up reset clears every register within 1 microsecond.
// [R09] After reset, enabled outputs show the cleared register through polarity.
// [R10] The clock stays static throughout power-up.
// [R11] No clock edge until input and feedback setup is satisfied.
// [R12] Undriven inputs and I/O pins read as logic 1.
// [R13] Preload breaks feedback and replaces next state for one edge only.
package prs_pkg;
  localparam int PRS_NCELL = 12;
  localparam int PRS_SIG_BITS = 64;
  localparam int PRS_CFG_WORDS = 16;
  localparam int PRS_CFG_BITS = 16;
  localparam int PRS_CLK_MHZ = 100;
  localparam int PRS_TPR_US = 1;
  // Longest time rounds down
  localparam int PRS_TPR_CYC = PRS_TPR_US * PRS_CLK_MHZ;
  localparam int PRS_ERASE_CYC = PRS_CFG_WORDS;
  localparam logic [PRS_CFG_BITS-1:0] PRS_ERASED = 16'hffff;
  localparam logic [PRS_CFG_BITS-1:0] PRS_REFUSED = 16'h0000;
  typedef enum logic [2:0] {
    PRS_PWRUP, PRS_RUN, PRS_ERASE, PRS_PROG
  } prs_state_t;
endpackage

// ==== prs_pullup.sv ====
// Pin input stage modelling the built-in pull-ups
`timescale 1ns/1ns
module prs_pullup #(
  parameter int W = 12
) (
  // Pin level and whether anything drives it
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] driven_in,
  // Resolved logic level
  output logic [W-1:0] level_out
);
  // Floating pins settle high
  assign level_out = pin_in | ~driven_in; // see [R12]
endmodule // prs_pullup

// ==== prs_core.sv ====
// Reset, preload, signature and security housekeeping for a macrocell array
`timescale 1ns/1ns
module prs_core import prs_pkg::*; #(
  parameter int NCELL = PRS_NCELL,
  parameter int TPR_CYC = PRS_TPR_CYC
) (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Macrocell next state, enables, polarity and pins
  input wire logic [NCELL-1:0] next_q_in,
  input wire logic [NCELL-1:0] oe_in,
  input wire logic [NCELL-1:0] polarity_in,
  input wire logic [NCELL-1:0] pin_in,
  input wire logic [NCELL-1:0] driven_in,
  // Preload
  input wire logic preload_in,
  input wire logic [NCELL-1:0] preload_val_in,
  // Programming
  input wire logic prog_start_in,
  input wire logic prog_wr_in,
  input wire logic [3:0] prog_addr_in,
  input wire logic [PRS_CFG_BITS-1:0] prog_data_in,
  input wire logic prog_secure_in,
  input wire logic prog_end_in,
  input wire logic sig_wr_in,
  input wire logic [PRS_SIG_BITS-1:0] sig_data_in,
  // Readback
  input wire logic cfg_rd_in,
  input wire logic [3:0] cfg_addr_in,
  // Outputs
  output logic [NCELL-1:0] q_out,
  output logic [NCELL-1:0] pin_out,
  output logic [NCELL-1:0] pin_oe_out,
  output logic [NCELL-1:0] pin_level_out,
  output logic [PRS_SIG_BITS-1:0] sig_out,
  output logic [PRS_CFG_BITS-1:0] cfg_data_out,
  output logic cfg_valid_out,
  output logic cfg_refused_out,
  output logic secure_out,
  output logic ready_out,
  output logic busy_out
);
  // Everything the block remembers lives in one registered struct, so
  // every output comes straight from a flip-flop. The array words are
  // the exception: they sit in their own memory and only reach the
  // outside through the registered readback word.
  // Limitation: the array image is not reset; it is only defined after
  // the first programming cycle has erased and rewritten it.
  typedef struct packed {
    // Sequencer
    prs_state_t st;
    logic [15:0] cnt;
    // Macrocell registers and the pin image built from them
    logic [NCELL-1:0] q;
    logic [NCELL-1:0] pin;
    logic [NCELL-1:0] oe;
    logic [NCELL-1:0] lvl;
    // Signature store
    logic [PRS_SIG_BITS-1:0] sig;
    // Readback result, held at zero unless a read was granted
    logic [PRS_CFG_BITS-1:0] rdata;
    logic rvalid;
    logic refused;
    // Protection and status
    logic secure;
    logic ready;
    logic busy;
  } prs_regs_t;

  prs_regs_t r;
  prs_regs_t next_r;
  logic [PRS_CFG_BITS-1:0] cfg_mem [PRS_CFG_WORDS];
  logic [NCELL-1:0] level;

  prs_pullup #(.W(NCELL)) u_pullup (
    .pin_in(pin_in),
    .driven_in(driven_in),
    .level_out(level)
  );

  // Polarity applied to a register value gives the pin value
  function automatic logic [NCELL-1:0] drive(
    input logic [NCELL-1:0] q, input logic [NCELL-1:0] pol);
    drive = q ^ pol;
  endfunction

  // True on the last cycle of a phase that lasts len cycles
  function automatic logic phase_done(
    input logic [15:0] cnt, input int len);
    phase_done = (cnt >= 16'(len - 1));
  endfunction

  // Step a phase counter; saturating so a stuck phase cannot wrap
  function automatic logic [15:0] phase_step(input logic [15:0] cnt);
    phase_step = (cnt == 16'hffff) ? cnt : cnt + 16'h0001;
  endfunction

  // A readback is granted only while the array is unprotected
  function automatic logic read_granted(input logic rd, input logic sec);
    read_granted = rd && !sec;
  endfunction

  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.refused = 1'b0;
    // Data drops back to zero with the strobe so nothing lingers
    next_r.rdata = PRS_REFUSED;
    next_r.lvl = level;
    case (r.st)
      PRS_PWRUP: begin
        // Registers already cleared by reset; hold off for tpr
        if (phase_done(r.cnt, TPR_CYC)) begin
          next_r.st = PRS_RUN; // see [R08]
          next_r.ready = 1'b1;
        end else begin
          next_r.cnt = phase_step(r.cnt);
        end
      end

      PRS_RUN: begin
        // Start wins over preload and readback in the same cycle
        if (prog_start_in) begin
          // Erase comes with every programming cycle
          next_r.st = PRS_ERASE; // see [R05]
          next_r.cnt = '0;
          next_r.busy = 1'b1;
          next_r.ready = 1'b0;
        end else if (preload_in) begin
          // Feedback broken for this edge only
          next_r.q = preload_val_in; // see [R06] see [R13]
        end else begin
          next_r.q = next_q_in;
        end
        // A read that meets a start is dropped rather than half served
        if (cfg_rd_in && !prog_start_in) begin
          if (read_granted(cfg_rd_in, r.secure)) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = cfg_mem[cfg_addr_in];
          end else begin
            next_r.refused = 1'b1; // see [R03]
          end
        end
      end

      PRS_ERASE: begin
        // The security cell clears here, as part of reprogramming, and otherwise only at power-up reset
        next_r.secure = 1'b0; // see [R04]
        // One array word is overwritten per cycle during the erase phase
        if (phase_done(r.cnt, PRS_ERASE_CYC)) begin
          next_r.st = PRS_PROG;
        end else begin
          next_r.cnt = phase_step(r.cnt);
        end
      end

      PRS_PROG: begin
        // The signature may be written anywhere in the programming window
        if (sig_wr_in) begin
          next_r.sig = sig_data_in; // see [R01]
        end
        if (prog_end_in) begin
          next_r.st = PRS_RUN;
          next_r.busy = 1'b0;
          next_r.ready = 1'b1;
          // Protection takes effect only once the pattern is complete
          next_r.secure = prog_secure_in;
        end
      end
      default: begin
        next_r.st = PRS_PWRUP;
      end
    endcase
    // Pin image follows the register through the programmed polarity
    next_r.pin = drive(next_r.q, polarity_in); // see [R09]
    next_r.oe = oe_in;
  end

  // Array words: erased in the erase phase, written during programming
  always_ff @(posedge clk_in) begin
    if (r.st == PRS_ERASE) begin
      cfg_mem[r.cnt[3:0]] <= PRS_ERASED; // see [R05]
    end else if (r.st == PRS_PROG && prog_wr_in) begin
      cfg_mem[prog_addr_in] <= prog_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0; // see [R08]
    end else begin
      r <= next_r;
    end
  end

  assign q_out = r.q;
  assign pin_out = r.pin;
  assign pin_oe_out = r.oe;
  assign pin_level_out = r.lvl;
  // Signature is never gated by the security cell
  assign sig_out = r.sig; // see [R02]
  // Zero whenever no granted read is standing
  assign cfg_data_out = r.rdata;
  assign cfg_valid_out = r.rvalid;
  assign cfg_refused_out = r.refused;
  assign secure_out = r.secure;
  assign ready_out = r.ready;
  assign busy_out = r.busy;
endmodule // prs_core

// ==== prs_tester.sv ====
// Test equipment model that preloads the registers
`timescale 1ns/1ns
module prs_tester (
  input wire logic clk_in,
  output logic pre_out = 1'b0,
  output logic [11:0] val_out = 12'h000
);
  // Released lines show the inverse so a stale value never passes
  task automatic preload(input logic [11:0] v);
    {pre_out, val_out} = {1'b1, v};
    @(posedge clk_in) #1;
    {pre_out, val_out} = {1'b0, ~v};
  endtask
endmodule // prs_tester

// ==== prs_core_asserts.sv ====
// Checker for the reset, preload and security block
`timescale 1ns/1ns
module prs_core_asserts import prs_pkg::*; #(parameter int NCELL = 12) (
  input wire logic clk_in, nrst_in, preload_in, prog_start_in, cfg_rd_in,
  input wire logic [NCELL-1:0] next_q_in, preload_val_in, pin_in,
  input wire logic [NCELL-1:0] driven_in, q_out, pin_level_out,
  input wire logic [15:0] cfg_data_out,
  input wire logic cfg_refused_out, secure_out, ready_out, busy_out);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_rst; $rose(nrst_in) |-> q_out == 0 && !ready_out; endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  property p_pre; ready_out && preload_in |=> q_out == $past(preload_val_in);
  endproperty
  a_pre: assert property (p_pre) else $error("no preload");
  property p_nxt; ready_out && !preload_in && !prog_start_in |=>
    q_out == $past(next_q_in); endproperty
  a_nxt: assert property (p_nxt) else $error("preload stuck");
  property p_ref; ready_out && cfg_rd_in && secure_out |=>
    cfg_refused_out && cfg_data_out == PRS_REFUSED; endproperty
  a_ref: assert property (p_ref) else $error("read leaked");
  property p_val; ready_out && cfg_rd_in && !secure_out |=> !cfg_refused_out;
  endproperty
  a_val: assert property (p_val) else $error("read refused");
  property p_era; prog_start_in && ready_out |-> ##[1:2] busy_out[*8];
  endproperty
  a_era: assert property (p_era) else $error("no erase");
  property p_clr; prog_start_in && ready_out |-> ##[1:17] !secure_out;
  endproperty
  a_clr: assert property (p_clr) else $error("secure kept");
  property p_lvl; nrst_in |=>
    pin_level_out == ($past(pin_in) | ~$past(driven_in)); endproperty
  a_lvl: assert property (p_lvl) else $error("pull-up lost");
  c_pre: cover property (ready_out && preload_in);
  c_ref: cover property (cfg_refused_out);
  c_era: cover property (busy_out);
endmodule // prs_core_asserts
bind prs_core prs_core_asserts #(.NCELL(NCELL)) chk (.*);

// ==== pld_reset_preload_security_bench.sv ====
// Bench for the reset, preload and security block
`timescale 1ns/1ns
module pld_reset_preload_security_bench import prs_pkg::*;;
  logic clk_in = 1'b0, nrst_in = 1'b1, prog_start_in = 1'b0;
  logic prog_wr_in = 1'b0, prog_secure_in = 1'b0, prog_end_in = 1'b0;
  logic sig_wr_in = 1'b0, cfg_rd_in = 1'b0, preload_in, cfg_refused_out;
  logic secure_out, ready_out, busy_out, cfg_valid_out;
  logic [11:0] pin_oe_out;
  logic [11:0] next_q_in, oe_in = 12'hfff, polarity_in, pin_in, driven_in, v;
  logic [11:0] preload_val_in, q_out, pin_out, pin_level_out;
  logic [3:0] cfg_addr_in = 4'h0, prog_addr_in = 4'h3;
  logic [15:0] prog_data_in = 16'h0000, cfg_data_out, d;
  logic [63:0] sig_data_in = 64'h0, sig_out, s;
  int seed = 32'hf01a8283, mismatches = 0, checked = 0, cyc = 0;
  prs_core #(.TPR_CYC(4)) uut (.*);
  prs_tester tst (.clk_in(clk_in), .pre_out(preload_in),
    .val_out(preload_val_in));
  // Clock stands still while power-up reset is applied
  always #5 if (nrst_in) clk_in = ~clk_in;
  function logic [11:0] lvl(logic [11:0] p, e); return p | ~e; endfunction
  task chk(input logic [63:0] g, e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tick;
    @(posedge clk_in) #1;
  endtask
  task prog(input logic c, input logic [15:0] w, input logic [63:0] g);
    prog_start_in = 1'b1; tick; prog_start_in = 1'b0;
    chk(busy_out, 1);
    repeat (PRS_ERASE_CYC + 2) tick;
    {prog_wr_in, sig_wr_in, prog_data_in, sig_data_in} = {2'h3, w, g}; tick;
    {prog_wr_in, sig_wr_in, prog_end_in, prog_secure_in} = {3'h1, c}; tick;
    prog_end_in = 1'b0; tick;
    chk({busy_out, ready_out}, 2'b01);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input logic r);
    {cfg_rd_in, cfg_addr_in} = {1'b1, a}; tick; cfg_rd_in = 1'b0;
    chk(cfg_data_out, e);
    chk(cfg_refused_out, r);
    chk(cfg_valid_out, !r);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin mismatches++; wrap_up; end
  end
  initial begin
    {next_q_in, pin_in, driven_in} = 36'h0;
    polarity_in = 12'($random(seed));
    // Reset edge comes with the clock still, held for five periods
    #1 nrst_in = 1'b0;
    #50 nrst_in = 1'b1;
    tick;
    chk(q_out, 0);
    // No vector until the block reports ready
    repeat (6) tick;
    chk(ready_out, 1);
    chk(pin_out, polarity_in);
    for (int i = 0; i < 6; i++) begin
      {next_q_in, pin_in, driven_in} = 36'({$random(seed), $random(seed)});
      oe_in = 12'($random(seed));
      v = i ? 12'($random(seed)) : 12'hfff;
      tst.preload(v);
      chk(q_out, v);
      tick;
      chk(q_out, next_q_in);
      chk(pin_level_out, lvl(pin_in, driven_in));
      chk(pin_oe_out, oe_in);
    end
    {d, s} = 80'({$random(seed), $random(seed), $random(seed)});
    prog(1'b0, d, s);
    rd(4'h3, d, 1'b0);
    rd(4'h5, PRS_ERASED, 1'b0);
    chk(sig_out, s);
    prog(1'b1, ~d, ~s);
    chk(secure_out, 1);
    rd(4'h3, PRS_REFUSED, 1'b1);
    chk(sig_out, ~s);
    prog(1'b0, d, s);
    chk(secure_out, 0);
    rd(4'h3, d, 1'b0);
    wrap_up;
  end
endmodule // pld_reset_preload_security_bench
